// file: src/fdi_pkg.sv
// Constants shared by the fast digital input block
package fdi_pkg;
    localparam int N_CH = 16;
    localparam int CNT_W = 24;
    localparam int FILT_W = 14;
    localparam int TS_W = 16;
    // Clock period and documented times, in nanoseconds
    localparam int CLK_NS = 4;
    localparam int T_PLAIN_NS = 2560;
    localparam int T_EXT_FIX_NS = 1000;
    localparam int T_STEP_NS = 2560;
    localparam int T_TICK_NS = 1000;
    // Least times round up to whole cycles
    localparam logic [CNT_W-1:0] PLAIN_CYC = CNT_W'((T_PLAIN_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [CNT_W-1:0] EXT_FIX_CYC = CNT_W'((T_EXT_FIX_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] STEP_CYC = 10'((T_STEP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] TICK_CYC = 8'(T_TICK_NS / CLK_NS);
    // Record set numbers and sizes
    localparam logic [7:0] REC_DIAG = 8'h7f;
    localparam logic [7:0] REC_EDGE = 8'h80;
    localparam logic [7:0] REC_FILT = 8'h81;
    localparam int PARAM_BYTES = 66;
    localparam logic [5:0] EDGE_TS_OFS = 6'h10;
    localparam logic [5:0] EDGE_REC_END = 6'h20;
    localparam logic [15:0] DIAG_ON = 16'h0001;
    localparam logic [FILT_W-1:0] FILT_MIN = 14'h0001;
    localparam logic [FILT_W-1:0] FILT_MAX = 14'h3e80;
    localparam logic [FILT_W-1:0] FILT_RST = 14'h0001;
    // Input image layout, byte offsets
    localparam logic [5:0] IMG_BYTES_PLAIN = 6'h02;
    localparam logic [5:0] IMG_BYTES_EXT = 6'h30;
    localparam logic [5:0] IMG_STATE = 6'h00;
    localparam logic [5:0] IMG_EDGE = 6'h04;
    localparam logic [5:0] IMG_LOST = 6'h08;
    localparam logic [5:0] IMG_TS = 6'h0c;
    localparam logic [5:0] IMG_TS_END = 6'h2c;
    // Two-bit edge codes
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_RISE = 2'h1;
    localparam logic [1:0] SEL_FALL = 2'h2;
    localparam logic [1:0] SEL_BOTH = 2'h3;
endpackage

// file: src/fdi_top.sv
// Sixteen-channel filtered fast input with edge events and time stamps
// Contract
// - Without extended configuration the block runs plain, shows two image bytes, takes no records.
// - Plain mode qualifies each input over a fixed 2.56 us before reporting it.
// - Extended mode shows 48 image bytes and is configured by 66 bytes of records.
// - Extended filter delay is 1 us plus the channel's programmed filter value.
// - Records come as diagnostic, edge and filter sets and apply at once, also while running.
// - Diagnostic word 0 equal to one enables the diagnostic interrupt, zero disables it.
// - An enabled diagnostic interrupt fires when an event retriggers while still being serviced.
// - The diagnostic enable is one global bit for all sixteen inputs.
// - Bits 1:0 of each edge byte pick none, rising, falling or both edges for the interrupt.
// - Edge bytes 0 to 15 map to channels 0 to 15 and their upper six bits are ignored.
// - Sixteen independent channels each drive a status indicator of the recognized state.
// - Time stamping and the filter value are set per channel in extended mode.
// - A filter value is a multiple of 2.56 us in the range 1 to 16000.
// - Edge bytes 16 to 31 pick the time stamp edge per channel with the same code.
// - Edge-detected flags latch any edge and clear when the controller reads them.
// - Image bytes 0 and 1 hold the filtered state, one bit per channel, one meaning set.
`timescale 1ns/100ps
`default_nettype none
module fdi_top (
    input wire logic clk_sys_i, // System clock, 250 MHz
    input wire logic rst_n_i, // Synchronous reset, active low
    input wire logic mode_ext_i, // Extended configuration present
    input wire logic [15:0] din_i, // Raw input pins
    input wire logic rec_wr_i, // Record byte write strobe
    input wire logic [7:0] rec_set_i, // Record set number
    input wire logic [5:0] rec_idx_i, // Byte index within record
    input wire logic [7:0] rec_data_i, // Record byte
    input wire logic img_rd_i, // Input image byte read strobe
    input wire logic [5:0] img_addr_i, // Image byte offset
    output logic [7:0] img_data_o, // Image byte, one cycle after read
    input wire logic [15:0] proc_ack_i, // Process interrupt serviced
    output logic [15:0] proc_irq_o, // Process interrupt pending
    output logic diag_irq_o, // Diagnostic interrupt pulse
    output logic [15:0] led_o // Channel status indicators
);
    localparam int N = fdi_pkg::N_CH;
    logic [N-1:0] sync1_ff, sync2_ff, filt_ff, prev_ff;
    logic [N-1:0] pend_ff, edge_ff, lost_ff, ev, ts_ev, hit;
    logic [fdi_pkg::CNT_W-1:0] cnt_ff [N];
    logic [fdi_pkg::CNT_W-1:0] thr [N];
    logic [fdi_pkg::FILT_W-1:0] fval_ff [N];
    logic [1:0] esel_ff [N];
    logic [1:0] tsel_ff [N];
    logic [fdi_pkg::TS_W-1:0] ts_ff [N];
    logic [15:0] diag_word_ff;
    logic [7:0] pre_ff;
    logic [fdi_pkg::TS_W-1:0] tick_ff;
    logic [7:0] img_data_ff;
    logic [7:0] nxt_img;
    logic diag_ff, diag_en, wr_ok, rd_edge_lo, rd_edge_hi, rd_lost_lo, rd_lost_hi;
    logic [5:0] ts_idx;

    // Two-flop input synchroniser
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= din_i;
            sync2_ff <= sync1_ff;
        end
    end

    // Records only accepted when configured extended
    assign wr_ok = rec_wr_i && mode_ext_i;
    assign diag_en = (diag_word_ff == fdi_pkg::DIAG_ON);

    // Diagnostic record, word 0 high byte first
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            diag_word_ff <= '0;
        end else if (wr_ok && rec_set_i == fdi_pkg::REC_DIAG && rec_idx_i < 6'h02) begin
            if (rec_idx_i[0]) begin
                diag_word_ff[7:0] <= rec_data_i;
            end else begin
                diag_word_ff[15:8] <= rec_data_i;
            end
        end
    end

    // Microsecond ticker for time stamps
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pre_ff <= '0;
            tick_ff <= '0;
        end else if (pre_ff == fdi_pkg::TICK_CYC - 8'h01) begin
            pre_ff <= '0;
            tick_ff <= tick_ff + 16'h0001;
        end else begin
            pre_ff <= pre_ff + 8'h01;
        end
    end

    // Reads of the flag bytes clear them
    assign rd_edge_lo = img_rd_i && img_addr_i == fdi_pkg::IMG_EDGE;
    assign rd_edge_hi = img_rd_i && img_addr_i == fdi_pkg::IMG_EDGE + 6'h01;
    assign rd_lost_lo = img_rd_i && img_addr_i == fdi_pkg::IMG_LOST;
    assign rd_lost_hi = img_rd_i && img_addr_i == fdi_pkg::IMG_LOST + 6'h01;

    // Per-channel filter, events, flags and time stamps
    for (genvar c = 0; c < N; c++) begin : g_ch
        logic [fdi_pkg::FILT_W-1:0] fcl;
        logic rise, fall, clr_e, clr_l;
        assign fcl = (fval_ff[c] < fdi_pkg::FILT_MIN) ? fdi_pkg::FILT_MIN :
                     (fval_ff[c] > fdi_pkg::FILT_MAX) ? fdi_pkg::FILT_MAX : fval_ff[c];
        assign thr[c] = mode_ext_i ?
            fdi_pkg::EXT_FIX_CYC +
            fdi_pkg::CNT_W'(fcl) * fdi_pkg::CNT_W'(fdi_pkg::STEP_CYC) :
            fdi_pkg::PLAIN_CYC;
        assign rise = filt_ff[c] && !prev_ff[c];
        assign fall = !filt_ff[c] && prev_ff[c];
        assign ev[c] = (rise && esel_ff[c][0]) || (fall && esel_ff[c][1]);
        assign ts_ev[c] = (rise && tsel_ff[c][0]) || (fall && tsel_ff[c][1]);
        assign hit[c] = ev[c] && pend_ff[c];
        assign clr_e = (c < 8) ? rd_edge_lo : rd_edge_hi;
        assign clr_l = (c < 8) ? rd_lost_lo : rd_lost_hi;

        // Persistence counter qualifies each change
        always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i) begin
                cnt_ff[c] <= '0;
                filt_ff[c] <= 1'b0;
                prev_ff[c] <= 1'b0;
            end else begin
                prev_ff[c] <= filt_ff[c];
                if (sync2_ff[c] == filt_ff[c]) begin
                    cnt_ff[c] <= '0;
                end else if (cnt_ff[c] + 24'h000001 >= thr[c]) begin
                    cnt_ff[c] <= '0;
                    filt_ff[c] <= sync2_ff[c];
                end else begin
                    cnt_ff[c] <= cnt_ff[c] + 24'h000001;
                end
            end
        end

        // Edge and filter records; upper edge bits dropped
        always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i) begin
                esel_ff[c] <= fdi_pkg::SEL_NONE;
                tsel_ff[c] <= fdi_pkg::SEL_NONE;
                fval_ff[c] <= fdi_pkg::FILT_RST;
            end else if (wr_ok) begin
                if (rec_set_i == fdi_pkg::REC_EDGE && rec_idx_i == 6'(c)) begin
                    esel_ff[c] <= rec_data_i[1:0];
                end
                if (rec_set_i == fdi_pkg::REC_EDGE && rec_idx_i == fdi_pkg::EDGE_TS_OFS + 6'(c)) begin
                    tsel_ff[c] <= rec_data_i[1:0];
                end
                if (rec_set_i == fdi_pkg::REC_FILT && rec_idx_i == 6'(2 * c)) begin
                    fval_ff[c][13:8] <= rec_data_i[5:0];
                end
                if (rec_set_i == fdi_pkg::REC_FILT && rec_idx_i == 6'(2 * c + 1)) begin
                    fval_ff[c][7:0] <= rec_data_i;
                end
            end
        end

        // Sticky flags, new event wins over clear
        always_ff @(posedge clk_sys_i) begin
            if (!rst_n_i) begin
                pend_ff[c] <= 1'b0;
                edge_ff[c] <= 1'b0;
                lost_ff[c] <= 1'b0;
                ts_ff[c] <= '0;
            end else begin
                pend_ff[c] <= ev[c] || (pend_ff[c] && !proc_ack_i[c]);
                edge_ff[c] <= (rise || fall) || (edge_ff[c] && !clr_e);
                lost_ff[c] <= ((rise || fall) && edge_ff[c]) || (lost_ff[c] && !clr_l);
                if (ts_ev[c]) begin
                    ts_ff[c] <= tick_ff;
                end
            end
        end
    end

    // Global diagnostic pulse
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            diag_ff <= 1'b0;
        end else begin
            diag_ff <= diag_en && (|hit);
        end
    end

    // Image byte select; out of range reads zero
    assign ts_idx = img_addr_i - fdi_pkg::IMG_TS;
    always_comb begin
        nxt_img = 8'h00;
        if (!mode_ext_i && img_addr_i < fdi_pkg::IMG_BYTES_PLAIN) begin
            nxt_img = img_addr_i[0] ? filt_ff[15:8] : filt_ff[7:0];
        end else if (mode_ext_i && img_addr_i < fdi_pkg::IMG_BYTES_EXT) begin
            if (img_addr_i == fdi_pkg::IMG_STATE || img_addr_i == fdi_pkg::IMG_STATE + 6'h01) begin
                nxt_img = img_addr_i[0] ? filt_ff[15:8] : filt_ff[7:0];
            end else if (rd_edge_lo || rd_edge_hi) begin
                nxt_img = img_addr_i[0] ? edge_ff[15:8] : edge_ff[7:0];
            end else if (rd_lost_lo || rd_lost_hi) begin
                nxt_img = img_addr_i[0] ? lost_ff[15:8] : lost_ff[7:0];
            end else if (img_addr_i >= fdi_pkg::IMG_TS && img_addr_i < fdi_pkg::IMG_TS_END) begin
                nxt_img = ts_idx[0] ? ts_ff[ts_idx[4:1]][15:8] : ts_ff[ts_idx[4:1]][7:0];
            end
        end
    end

    // Registered read data
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            img_data_ff <= '0;
        end else if (img_rd_i) begin
            img_data_ff <= nxt_img;
        end
    end

    assign img_data_o = img_data_ff;
    assign proc_irq_o = pend_ff;
    assign diag_irq_o = diag_ff;
    assign led_o = filt_ff;

    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    AST_PLAIN_IMG: assert property (
        img_rd_i && !mode_ext_i && img_addr_i >= fdi_pkg::IMG_BYTES_PLAIN |=> img_data_o == 8'h00)
        else $error("plain mode image beyond two bytes not zero");
    AST_PLAIN_DELAY: assert property (
        !mode_ext_i && $changed(filt_ff[0]) |-> $past(cnt_ff[0]) == fdi_pkg::PLAIN_CYC - 24'h000001)
        else $error("plain filter delay wrong");
    AST_EXT_IMG: assert property (
        img_rd_i && mode_ext_i && img_addr_i >= fdi_pkg::IMG_BYTES_EXT |=> img_data_o == 8'h00)
        else $error("extended image beyond 48 bytes not zero");
    AST_EXT_DELAY: assert property (
        $past(mode_ext_i) && $changed(filt_ff[0]) |-> $past(cnt_ff[0]) == $past(thr[0]) - 24'h000001)
        else $error("extended filter delay wrong");
    AST_DIAG_GATE: assert property (
        diag_irq_o |-> $past(diag_word_ff) == fdi_pkg::DIAG_ON)
        else $error("diagnostic raised while disabled");
    AST_DIAG_RAISE: assert property (
        diag_en && ev[2] && pend_ff[2] |=> diag_irq_o)
        else $error("retrigger did not raise diagnostic");
    AST_EDGE_RISE: assert property (
        filt_ff[0] && !prev_ff[0] && esel_ff[0][0] |=> pend_ff[0])
        else $error("rising edge did not set pending");
    AST_NO_SEL: assert property (
        esel_ff[3] == fdi_pkg::SEL_NONE && !pend_ff[3] && $stable(esel_ff[3]) |=> !pend_ff[3])
        else $error("pending without selected edge");
    AST_FLAG_CLR: assert property (
        rd_edge_lo && filt_ff[0] == prev_ff[0] ##1 filt_ff[0] == prev_ff[0] |-> !edge_ff[0])
        else $error("edge flag not cleared by read");
    AST_STATE_IMG: assert property (
        img_rd_i && img_addr_i == fdi_pkg::IMG_STATE |=> img_data_o == $past(filt_ff[7:0]))
        else $error("state byte mismatch");
    AST_TS_CAP: assert property (
        ts_ev[2] |=> ts_ff[2] == $past(tick_ff))
        else $error("time stamp not captured");

    COV_DIAG: cover property (diag_irq_o);
    COV_EXT_EDGE: cover property (mode_ext_i && ev[0]);
    COV_LOST_READ: cover property (rd_lost_lo && lost_ff[0]);
    COV_TS: cover property (ts_ev[2]);
endmodule
`default_nettype wire

// file: tb/fdi_cpu_model.sv
// Controller-side model: record writes, image reads, interrupt service
`timescale 1ns/100ps
`default_nettype none
module fdi_cpu_model (
    input wire logic clk_sys_i, // System clock
    output logic rec_wr_o, // Record byte strobe
    output logic [7:0] rec_set_o, // Record set number
    output logic [5:0] rec_idx_o, // Byte index in record
    output logic [7:0] rec_data_o, // Record byte
    output logic img_rd_o, // Image read strobe
    output logic [5:0] img_addr_o, // Image byte offset
    input wire logic [7:0] img_data_i, // Image byte returned
    output logic [15:0] proc_ack_o // Process interrupt serviced
);
    // Idle bus until the first request
    initial begin
        rec_wr_o = 1'b0;
        rec_set_o = 8'h00;
        rec_idx_o = 6'h00;
        rec_data_o = 8'h00;
        img_rd_o = 1'b0;
        img_addr_o = 6'h00;
        proc_ack_o = 16'h0000;
    end
    // One record byte; released lines show the inverse, never the old value
    task automatic wr_rec(input logic [7:0] set, input logic [5:0] idx, input logic [7:0] data);
        @(posedge clk_sys_i);
        rec_wr_o <= 1'b1;
        rec_set_o <= set;
        rec_idx_o <= idx;
        rec_data_o <= data;
        @(posedge clk_sys_i);
        rec_wr_o <= 1'b0;
        rec_set_o <= ~set;
        rec_idx_o <= ~idx;
        rec_data_o <= ~data;
    endtask
    // Channel filter word, high byte first, written unclamped; the block clamps it to 1 to 16000
    task automatic wr_filt(input int ch, input logic [13:0] val);
        wr_rec(fdi_pkg::REC_FILT, 6'(2 * ch), {2'h0, val[13:8]});
        wr_rec(fdi_pkg::REC_FILT, 6'(2 * ch + 1), val[7:0]);
    endtask
    // Image byte read, data taken one cycle after the strobe
    task automatic rd_img(input logic [5:0] addr, output logic [7:0] data);
        @(posedge clk_sys_i);
        img_rd_o <= 1'b1;
        img_addr_o <= addr;
        @(posedge clk_sys_i);
        img_rd_o <= 1'b0;
        img_addr_o <= ~addr;
        @(posedge clk_sys_i);
        data = img_data_i;
    endtask
    // Service pulse for the selected channels
    task automatic ack(input logic [15:0] mask);
        @(posedge clk_sys_i);
        proc_ack_o <= mask;
        @(posedge clk_sys_i);
        proc_ack_o <= 16'h0000;
    endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the fast digital input block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk_sys_i, rst_n_i, mode_ext_i, rec_wr, img_rd, diag_irq;
    logic [15:0] din_i, proc_ack, proc_irq, led;
    logic [7:0] rec_set, rec_data, img_data;
    logic [5:0] rec_idx, img_addr;
    int errors, checked, diag_n;
    fdi_top dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .mode_ext_i(mode_ext_i),
        .din_i(din_i), .rec_wr_i(rec_wr), .rec_set_i(rec_set), .rec_idx_i(rec_idx),
        .rec_data_i(rec_data), .img_rd_i(img_rd), .img_addr_i(img_addr),
        .img_data_o(img_data), .proc_ack_i(proc_ack), .proc_irq_o(proc_irq),
        .diag_irq_o(diag_irq), .led_o(led));
    fdi_cpu_model cpu_u (.clk_sys_i(clk_sys_i), .rec_wr_o(rec_wr), .rec_set_o(rec_set),
        .rec_idx_o(rec_idx), .rec_data_o(rec_data), .img_rd_o(img_rd), .img_addr_o(img_addr),
        .img_data_i(img_data), .proc_ack_o(proc_ack));
    // Clock and diagnostic pulse count
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) if (diag_irq === 1'b1) diag_n++;
    task automatic wrap_up();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [5:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        cpu_u.rd_img(addr, d);
        chk($sformatf("image byte %0d", addr), {8'h00, exp}, {8'h00, d});
    endtask
    // Bounded wait for masked indicator value
    task automatic wait_led(input logic [15:0] mask, input logic [15:0] exp, input int max);
        int n;
        n = 0;
        while ((led & mask) !== exp && n < max) begin
            @(posedge clk_sys_i);
            n++;
        end
        chk("indicator wait", exp, led & mask);
        if ((led & mask) !== exp) wrap_up();
    endtask
    task automatic set_din(input logic [15:0] v);
        @(posedge clk_sys_i);
        din_i <= v;
    endtask
    task automatic t_plain();
        set_din(16'h00a5);
        repeat (600) @(posedge clk_sys_i);
        chk("plain early", 16'h0000, led);
        wait_led(16'hffff, 16'h00a5, 100);
        rd_chk(6'h00, 8'ha5);
        rd_chk(6'h01, 8'h00);
        rd_chk(6'h04, 8'h00);
        set_din(16'h0000);
        wait_led(16'hffff, 16'h0000, 700);
        $display("test plain done");
    endtask
    task automatic t_ext();
        @(posedge clk_sys_i);
        mode_ext_i <= 1'b1;
        cpu_u.wr_rec(fdi_pkg::REC_DIAG, 6'h00, 8'h00);
        cpu_u.wr_rec(fdi_pkg::REC_DIAG, 6'h01, 8'h01);
        cpu_u.wr_rec(fdi_pkg::REC_EDGE, 6'h00, 8'hfd);
        cpu_u.wr_rec(fdi_pkg::REC_EDGE, 6'h01, 8'h02);
        cpu_u.wr_rec(fdi_pkg::REC_EDGE, 6'h02, 8'h03);
        cpu_u.wr_rec(fdi_pkg::REC_EDGE, 6'h03, 8'hfc);
        cpu_u.wr_filt(4, 14'h0002);
        cpu_u.wr_rec(fdi_pkg::REC_EDGE, 6'h12, 8'h03);
        rd_chk(6'h04, 8'ha5);
        rd_chk(6'h08, 8'h00);
        set_din(16'h001f);
        repeat (850) @(posedge clk_sys_i);
        chk("ext early", 16'h0000, led);
        wait_led(16'h000f, 16'h000f, 100);
        chk("slow channel", 16'h0000, led & 16'h0010);
        repeat (2) @(posedge clk_sys_i);
        chk("rise pending", 16'h0005, proc_irq);
        wait_led(16'h0010, 16'h0010, 700);
        rd_chk(6'h04, 8'h1f);
        rd_chk(6'h04, 8'h00);
        rd_chk(6'h00, 8'h1f);
        cpu_u.ack(16'hffff);
        @(posedge clk_sys_i);
        chk("pending cleared", 16'h0000, proc_irq);
        set_din(16'h0000);
        wait_led(16'hffff, 16'h0000, 1600);
        repeat (2) @(posedge clk_sys_i);
        chk("fall pending", 16'h0006, proc_irq);
        chk("no diag yet", 16'h0000, 16'(diag_n));
        set_din(16'h0004);
        wait_led(16'h0004, 16'h0004, 1000);
        repeat (3) @(posedge clk_sys_i);
        chk("diag retrigger", 16'h0001, 16'(diag_n));
        rd_chk(6'h08, 8'h04);
        rd_chk(6'h12, 8'h00);
        cpu_u.wr_rec(fdi_pkg::REC_DIAG, 6'h01, 8'h00);
        set_din(16'h0000);
        wait_led(16'h0004, 16'h0000, 1000);
        repeat (3) @(posedge clk_sys_i);
        chk("diag off", 16'h0001, 16'(diag_n));
        $display("test extended done");
    endtask
    task automatic t_pulse();
        cpu_u.ack(16'hffff);
        set_din(16'h0001);
        repeat (300) @(posedge clk_sys_i);
        set_din(16'h0000);
        repeat (1200) @(posedge clk_sys_i);
        chk("short pulse led", 16'h0000, led);
        chk("short pulse irq", 16'h0000, proc_irq);
        $display("test pulse done");
    endtask
    // Reset, then the scenarios in order
    initial begin
        errors = 0;
        checked = 0;
        diag_n = 0;
        rst_n_i = 1'b0;
        mode_ext_i = 1'b0;
        din_i = 16'h0000;
        repeat (10) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_plain();
        t_ext();
        t_pulse();
        wrap_up();
    end
endmodule
`default_nettype wire
